// *** pbt_pkg.sv ***
package pbt_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus and register map (register index, byte address is index times four)
  localparam int unsigned ADDR_W          = 12;
  localparam int unsigned IDX_LSB         = 2;
  localparam int unsigned IDX_W           = 8;
  localparam logic [7:0]  IDX_BYTE_CNT    = 8'h71;
  localparam logic [7:0]  IDX_CTRL_STS    = 8'h72;
  localparam logic [7:0]  IDX_PKT_LEN     = 8'h7B;
  localparam logic [7:0]  IDX_GAP_LEN     = 8'h7C;
  localparam logic [7:0]  IDX_CFG         = 8'h80;
  localparam logic [7:0]  IDX_IRQ_STS     = 8'h81;
  localparam logic [7:0]  IDX_IRQ_MASK    = 8'h82;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Control and status bit positions
  localparam int unsigned BIT_LOCK        = 0;
  localparam int unsigned BIT_LOCK_CLR    = 1;
  localparam int unsigned BIT_BYTE_OVF    = 9;
  localparam int unsigned BIT_PKT_OVF     = 10;
  localparam int unsigned CFG_GEN_EN      = 0;
  localparam int unsigned CFG_CNT_MODE    = 1;
  localparam int unsigned CFG_W           = 2;
  localparam int unsigned EV_ERR          = 0;
  localparam int unsigned EV_BYTE_OVF     = 1;
  localparam int unsigned EV_PKT_OVF      = 2;
  localparam int unsigned EV_W            = 3;

  // Reset values
  localparam logic [15:0] RST_PKT_LEN     = 16'h05DC;
  localparam logic [7:0]  RST_GAP_LEN     = 8'h7D;
  localparam logic [1:0]  RST_CFG         = 2'h0;
  localparam logic [7:0]  LFSR_SEED       = 8'h01;

  // Frame layout, in nibbles on the transmit side
  localparam logic [16:0] PRE_NIBBLES     = 17'h0000_D;
  localparam logic [3:0]  PRE_NIB         = 4'h5;
  localparam logic [7:0]  SFD_BYTE        = 8'hD5;
  localparam int unsigned GAP_BYTES_UNIT  = 4;
  localparam int unsigned NIB_PER_BYTE    = 2;
  localparam int unsigned GAP_SHIFT       = $clog2(GAP_BYTES_UNIT * NIB_PER_BYTE);

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic       en;
    logic [3:0] nib;
  } pbt_tx_t;

  typedef struct packed {
    logic       valid;
    logic       first;
    logic [7:0] data;
  } pbt_rx_t;

  typedef struct packed {
    logic [7:0]  err;
    logic [15:0] bytes;
    logic        byte_ovf;
    logic        pkt_ovf;
  } pbt_cnt_t;

  typedef enum logic [3:0] {
    GEN_IDLE = 4'h1,
    GEN_PRE  = 4'h2,
    GEN_DATA = 4'h4,
    GEN_GAP  = 4'h8
  } pbt_gen_st_t;

  // Pseudo-random byte sequence step shared by generator and checker
  function automatic logic [7:0] pbt_lfsr_step(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

endpackage

// *** pbt_gen.sv ***
module pbt_gen (
  // Clock and reset
  input  wire logic           i_clk,
  input  wire logic           i_rst_n,
  // Settings
  input  wire logic           i_en,
  input  wire logic [15:0]    i_pkt_len,
  input  wire logic [7:0]     i_gap_len,
  // Nibble stream out
  output pbt_pkg::pbt_tx_t    o_tx
);
  import pbt_pkg::*;

  typedef struct packed {
    pbt_gen_st_t st;
    logic [16:0] cnt;
    logic [16:0] data_last;
    logic [16:0] gap_last;
    logic        gap_zero;
    logic        len_zero;
    logic [7:0]  lfsr;
    pbt_tx_t     tx;
  } pbt_gen_state_t;

  pbt_gen_state_t s;
  pbt_gen_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame sequencer
  always_comb begin
    next_s       = s;
    next_s.tx.en = 1'b0;
    next_s.tx.nib = '0;
    unique case (s.st)
      GEN_IDLE: begin
        next_s.cnt = '0;
        if (i_en) begin
          next_s.st        = GEN_PRE;
          next_s.lfsr      = LFSR_SEED;                              // Every packet restarts the sequence
          next_s.len_zero  = (i_pkt_len == '0);
          next_s.data_last = {i_pkt_len, 1'b0} - 17'h0000_1;
          next_s.gap_zero  = (i_gap_len == '0);
          next_s.gap_last  = (17'(i_gap_len) << GAP_SHIFT) - 17'h0000_1;
        end
      end
      GEN_PRE: begin
        next_s.tx.en = 1'b1;
        if (s.cnt < PRE_NIBBLES) begin
          next_s.tx.nib = PRE_NIB;
        end else if (s.cnt == PRE_NIBBLES) begin
          next_s.tx.nib = SFD_BYTE[3:0];
        end else begin
          next_s.tx.nib = SFD_BYTE[7:4];
        end
        next_s.cnt = s.cnt + 17'h0000_1;
        if (s.cnt == PRE_NIBBLES + 17'h0000_1) begin
          next_s.cnt = '0;
          if (!s.len_zero) begin
            next_s.st = GEN_DATA;
          end else if (!s.gap_zero) begin
            next_s.st = GEN_GAP;
          end else begin
            next_s.st = GEN_IDLE;
          end
        end
      end
      GEN_DATA: begin
        next_s.tx.en  = 1'b1;
        next_s.tx.nib = s.cnt[0] ? s.lfsr[7:4] : s.lfsr[3:0];
        if (s.cnt[0]) begin
          next_s.lfsr = pbt_lfsr_step(s.lfsr);
        end
        next_s.cnt = s.cnt + 17'h0000_1;
        if (s.cnt == s.data_last) begin
          next_s.cnt = '0;
          next_s.st  = s.gap_zero ? GEN_IDLE : GEN_GAP;
        end
      end
      GEN_GAP: begin
        next_s.cnt = s.cnt + 17'h0000_1;
        if (s.cnt == s.gap_last) begin
          next_s.cnt = '0;
          next_s.st  = GEN_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s      <= '0;
      s.st   <= GEN_IDLE;
      s.lfsr <= LFSR_SEED;
    end else begin
      s <= next_s;
    end
  end

  assign o_tx = s.tx;

endmodule

// *** pbt_chk.sv ***
module pbt_chk (
  // Clock and reset
  input  wire logic           i_clk,
  input  wire logic           i_rst_n,
  // Received byte stream
  input  pbt_pkg::pbt_rx_t    i_rx,
  // Control
  input  wire logic           i_cnt_mode,
  input  wire logic           i_lock,
  input  wire logic           i_clear,
  // Snapshot and events
  output pbt_pkg::pbt_cnt_t   o_snap,
  output wire logic [pbt_pkg::EV_W-1:0] o_evt
);
  import pbt_pkg::*;

  typedef struct packed {
    logic [7:0]      prev;
    logic [7:0]      err;
    logic [15:0]     bytes;
    logic [15:0]     pkts;
    logic            byte_ovf;
    logic            pkt_ovf;
    pbt_cnt_t        snap;
    logic [EV_W-1:0] evt;
  } pbt_chk_state_t;

  pbt_chk_state_t s;
  pbt_chk_state_t next_s;
  logic           inc_err;
  logic           inc_byte;
  logic           inc_pkt;
  logic           wrap_byte;
  logic           wrap_pkt;

  ////////////////////////////////////////////////////////////////////////////////
  // Counting, overflow and snapshot
  always_comb begin
    next_s    = s;
    inc_byte  = i_rx.valid;
    inc_pkt   = i_rx.valid && i_rx.first;
    inc_err   = i_rx.valid && !i_rx.first && (i_rx.data != pbt_lfsr_step(s.prev));
    wrap_byte = inc_byte && (&s.bytes);
    wrap_pkt  = inc_pkt && (&s.pkts);
    if (i_rx.valid) begin
      next_s.prev = i_rx.data;
    end
    // Saturate in mode zero, wrap otherwise
    if (inc_err && !(!i_cnt_mode && (&s.err))) begin
      next_s.err = s.err + 8'h01;
    end
    if (inc_byte && !(!i_cnt_mode && (&s.bytes))) begin
      next_s.bytes = s.bytes + 16'h0001;
    end
    if (inc_pkt && !(!i_cnt_mode && (&s.pkts))) begin
      next_s.pkts = s.pkts + 16'h0001;
    end
    // Lock captures live values for software
    if (i_lock || i_clear) begin
      next_s.snap = {s.err, s.bytes, s.byte_ovf, s.pkt_ovf};
    end
    // Clear zeroes counters, a same-cycle count survives
    if (i_clear) begin
      next_s.err      = {7'h00, inc_err};
      next_s.bytes    = {15'h0000, inc_byte};
      next_s.pkts     = {15'h0000, inc_pkt};
      next_s.byte_ovf = 1'b0;
      next_s.pkt_ovf  = 1'b0;
    end
    // Overflow flags, set wins over clear
    if (wrap_byte) begin
      next_s.byte_ovf = 1'b1;
    end
    if (wrap_pkt) begin
      next_s.pkt_ovf = 1'b1;
    end
    next_s.snap.byte_ovf = next_s.byte_ovf;
    next_s.snap.pkt_ovf  = next_s.pkt_ovf;
    next_s.evt           = '0;
    next_s.evt[EV_ERR]      = inc_err;
    next_s.evt[EV_BYTE_OVF] = wrap_byte;
    next_s.evt[EV_PKT_OVF]  = wrap_pkt;
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s      <= '0;
      s.prev <= LFSR_SEED;
    end else begin
      s <= next_s;
    end
  end

  assign o_snap = s.snap;
  assign o_evt  = s.evt;

endmodule

// *** pbt_top.sv ***
// Notes on behaviour
// - An 8-bit error counter counts every received byte that breaks the pseudo-random sequence.
// - With the saturate mode setting at zero the error counter stops at all ones instead of wrapping.
// - Writing the lock bit of the control/status register freezes the counters into a readable snapshot.
// - Writing the lock-and-clear bit snapshots the counters and then zeroes them.
// - A read-only packet overflow flag sets on packet counter wrap and stays until a lock-and-clear.
// - A read-only byte overflow flag sets on byte counter wrap and clears only with a lock-and-clear.
// - Every generated packet carries exactly the number of payload bytes in the 16-bit length register.
// - Each packet opens with thirteen nibbles of five and then the start-of-frame byte.
// - An idle gap set by the 8-bit gap field, reset value meaning 500 bytes, separates packets.
// - Each unit of the gap field adds four bytes of idle gap.
// - A 16-bit byte counter counts all received bytes, is captured into the snapshot by lock writes and saturates in mode zero.
//
// Added by the designer: register access over AXI4-Lite.
module pbt_top (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  // AXI4-Lite write address
  input  wire logic                       i_awvalid,
  input  wire logic [pbt_pkg::ADDR_W-1:0] i_awaddr,
  output logic                            o_awready,
  // AXI4-Lite write data
  input  wire logic                       i_wvalid,
  input  wire logic [31:0]                i_wdata,
  input  wire logic [3:0]                 i_wstrb,
  output logic                            o_wready,
  // AXI4-Lite write response
  output logic                            o_bvalid,
  output logic [1:0]                      o_bresp,
  input  wire logic                       i_bready,
  // AXI4-Lite read address
  input  wire logic                       i_arvalid,
  input  wire logic [pbt_pkg::ADDR_W-1:0] i_araddr,
  output logic                            o_arready,
  // AXI4-Lite read data
  output logic                            o_rvalid,
  output logic [31:0]                     o_rdata,
  output logic [1:0]                      o_rresp,
  input  wire logic                       i_rready,
  // Test streams
  output pbt_pkg::pbt_tx_t                o_tx,
  input  pbt_pkg::pbt_rx_t                i_rx,
  // Interrupt
  output logic                            o_irq
);
  import pbt_pkg::*;

  typedef struct packed {
    logic              awrdy;
    logic              awv;
    logic [IDX_W-1:0]  awidx;
    logic              wrdy;
    logic              wv;
    logic [31:0]       wd;
    logic [3:0]        ws;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arrdy;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [15:0]       pkt_len;
    logic [7:0]        gap_len;
    logic [CFG_W-1:0]  cfg;
    logic [EV_W-1:0]   ists;
    logic [EV_W-1:0]   imask;
    logic              lock;
    logic              clr;
    logic              irq;
  } pbt_top_state_t;

  pbt_top_state_t  s;
  pbt_top_state_t  next_s;
  pbt_cnt_t        snap;
  logic [EV_W-1:0] evt;
  logic [IDX_W-1:0] ar_idx;
  logic            rd_clr;

  ////////////////////////////////////////////////////////////////////////////////
  // Generator and checker
  pbt_gen u_gen (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_en      (s.cfg[CFG_GEN_EN]),
    .i_pkt_len (s.pkt_len),
    .i_gap_len (s.gap_len),
    .o_tx      (o_tx)
  );

  pbt_chk u_chk (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_rx       (i_rx),
    .i_cnt_mode (s.cfg[CFG_CNT_MODE]),
    .i_lock     (s.lock),
    .i_clear    (s.clr),
    .o_snap     (snap),
    .o_evt      (evt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus slave and register file
  always_comb begin
    next_s      = s;
    next_s.lock = 1'b0;
    next_s.clr  = 1'b0;
    ar_idx      = i_araddr[IDX_LSB +: IDX_W];
    rd_clr      = 1'b0;

    // Address and data taken independently
    if (i_awvalid && s.awrdy) begin
      next_s.awv   = 1'b1;
      next_s.awidx = i_awaddr[IDX_LSB +: IDX_W];
    end
    if (i_wvalid && s.wrdy) begin
      next_s.wv = 1'b1;
      next_s.wd = i_wdata;
      next_s.ws = i_wstrb;
    end

    // Write once both halves are held
    if (s.awv && s.wv && !s.bvalid) begin
      next_s.awv    = 1'b0;
      next_s.wv     = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = RESP_OKAY;
      unique case (s.awidx)
        IDX_CTRL_STS: begin
          if (s.ws[0]) begin
            next_s.lock = s.wd[BIT_LOCK];
            next_s.clr  = s.wd[BIT_LOCK_CLR];
          end
        end
        IDX_PKT_LEN: begin
          if (s.ws[0]) begin
            next_s.pkt_len[7:0] = s.wd[7:0];
          end
          if (s.ws[1]) begin
            next_s.pkt_len[15:8] = s.wd[15:8];
          end
        end
        IDX_GAP_LEN: begin
          if (s.ws[0]) begin
            next_s.gap_len = s.wd[7:0];
          end
        end
        IDX_CFG: begin
          if (s.ws[0]) begin
            next_s.cfg = s.wd[CFG_W-1:0];
          end
        end
        IDX_IRQ_MASK: begin
          if (s.ws[0]) begin
            next_s.imask = s.wd[EV_W-1:0];
          end
        end
        IDX_BYTE_CNT, IDX_IRQ_STS: begin
          next_s.bresp = RESP_OKAY;                                  // Read-only, write ignored
        end
        default: begin
          next_s.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (s.bvalid && i_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Read answer from snapshot and settings
    if (s.rvalid && i_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (i_arvalid && s.arrdy) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = '0;
      next_s.rresp  = RESP_OKAY;
      unique case (ar_idx)
        IDX_BYTE_CNT: next_s.rdata[15:0] = snap.bytes;
        IDX_CTRL_STS: begin
          next_s.rdata[7:0]          = snap.err;
          next_s.rdata[BIT_BYTE_OVF] = snap.byte_ovf;
          next_s.rdata[BIT_PKT_OVF]  = snap.pkt_ovf;
        end
        IDX_PKT_LEN:  next_s.rdata[15:0]     = s.pkt_len;
        IDX_GAP_LEN:  next_s.rdata[7:0]      = s.gap_len;
        IDX_CFG:      next_s.rdata[CFG_W-1:0] = s.cfg;
        IDX_IRQ_STS: begin
          next_s.rdata[EV_W-1:0] = s.ists;
          rd_clr                 = 1'b1;
        end
        IDX_IRQ_MASK: next_s.rdata[EV_W-1:0] = s.imask;
        default:      next_s.rresp = RESP_SLVERR;
      endcase
    end

    // Sticky status, new event wins over read clear
    next_s.ists = (rd_clr ? '0 : s.ists) | evt;
    next_s.irq  = |(next_s.ists & s.imask);

    // Ready flags for the next cycle
    next_s.awrdy = !next_s.awv && !next_s.bvalid;
    next_s.wrdy  = !next_s.wv && !next_s.bvalid;
    next_s.arrdy = !next_s.rvalid;
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s         <= '0;
      s.awrdy   <= 1'b1;
      s.wrdy    <= 1'b1;
      s.arrdy   <= 1'b1;
      s.pkt_len <= RST_PKT_LEN;
      s.gap_len <= RST_GAP_LEN;
      s.cfg     <= RST_CFG;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops
  assign o_awready = s.awrdy;
  assign o_wready  = s.wrdy;
  assign o_bvalid  = s.bvalid;
  assign o_bresp   = s.bresp;
  assign o_arready = s.arrdy;
  assign o_rvalid  = s.rvalid;
  assign o_rdata   = s.rdata;
  assign o_rresp   = s.rresp;
  assign o_irq     = s.irq;

endmodule

// *** pbt_top_chk.sv ***
module pbt_top_chk (
  // Clock and reset
  input wire logic                       i_clk,
  input wire logic                       i_rst_n,
  // Write channels
  input wire logic                       i_awvalid,
  input wire logic                       o_awready,
  input wire logic                       i_wvalid,
  input wire logic                       o_wready,
  input wire logic                       o_bvalid,
  // Read channels
  input wire logic                       i_arvalid,
  input wire logic [pbt_pkg::ADDR_W-1:0] i_araddr,
  input wire logic                       o_arready,
  input wire logic                       o_rvalid,
  input wire logic [31:0]                o_rdata,
  input wire logic [1:0]                 o_rresp,
  input wire logic                       i_rready,
  // Stream and interrupt
  input wire pbt_pkg::pbt_tx_t           o_tx,
  input wire logic                       o_irq
);
  import pbt_pkg::*;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Fourteen fives then the delimiter high nibble
  sequence pre_s;
    (o_tx.en && o_tx.nib == PRE_NIB) [*7] ##1 (o_tx.en && o_tx.nib == PRE_NIB) [*7]
      ##1 (o_tx.en && o_tx.nib == SFD_BYTE[7:4]);
  endsequence

  ////////////////////////////////////////
  // Frame and bus relations
  pre_nibs_a: assert property ($rose(o_tx.en) |-> pre_s)
    else $error("frame opening nibbles wrong");
  b_lat_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
    else $error("write response late");
  r_lat_a: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data late");
  r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
    else $error("read data not held");
  ready_back_a: assert property ($fell(o_bvalid) |-> o_awready && o_wready)
    else $error("write readies not back");
  w_block_a: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted during response");
  ar_block_a: assert property (o_rvalid |-> !o_arready)
    else $error("read accepted during data");
  unm_rd_a: assert property (i_arvalid && o_arready && i_araddr[11:10] == 2'h0 && i_araddr[9:2] > IDX_IRQ_MASK
    |=> o_rresp == RESP_SLVERR && o_rdata == 32'h0000_0000)
    else $error("unmapped read answer wrong");

  // Main scenarios
  cover property ($rose(o_tx.en));
  cover property ($rose(o_irq));
  cover property (o_rvalid && o_rresp == RESP_SLVERR);
endmodule

bind pbt_top pbt_top_chk u_top_chk (
  .i_clk, .i_rst_n, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid,
  .i_arvalid, .i_araddr, .o_arready, .o_rvalid, .o_rdata, .o_rresp, .i_rready, .o_tx, .o_irq
);

// *** tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pbt_pkg::*;

  logic              i_clk, i_rst_n, o_irq;
  logic              i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic              o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [ADDR_W-1:0] i_awaddr, i_araddr;
  logic [31:0]       i_wdata, o_rdata;
  logic [3:0]        i_wstrb;
  logic [1:0]        o_bresp, o_rresp;
  pbt_tx_t           o_tx;
  pbt_rx_t           i_rx;
  int                err_total = 0;
  int                num_checks = 0;
  int                cyc = 0;
  int                e, len, g1, g2, lo0, lo1, lo2;
  logic [7:0]        x;
  logic [33:0]       q_rd[$];
  logic [1:0]        q_b[$];

  pbt_top dut (
    .i_clk, .i_rst_n, .i_awvalid, .i_awaddr, .o_awready, .i_wvalid, .i_wdata, .i_wstrb, .o_wready,
    .o_bvalid, .o_bresp, .i_bready, .i_arvalid, .i_araddr, .o_arready, .o_rvalid, .o_rdata,
    .o_rresp, .i_rready, .o_tx, .i_rx, .o_irq
  );

  // Clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  ////////////////////////////////////////
  // Helpers
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic cmp(input string nm, input logic [33:0] ex, input logic [33:0] got);
    num_checks++;
    if (got !== ex) begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, ex, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    logic a;
    logic w;
    q_b.push_back(r);
    i_awaddr  <= {2'h0, idx, 2'h0};
    i_wdata   <= d;
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_bready  <= 1'b1;
    a = 1'b1;
    w = 1'b1;
    do begin
      @(posedge i_clk);
      a = a && !o_awready;
      w = w && !o_wready;
      i_awvalid <= a;
      i_wvalid  <= w;
    end while (a || w);
    do @(posedge i_clk); while (o_bvalid !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] ex, input logic [1:0] r = RESP_OKAY);
    q_rd.push_back({r, ex});
    i_araddr  <= {2'h0, idx, 2'h0};
    i_arvalid <= 1'b1;
    do @(posedge i_clk); while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    repeat ($urandom_range(0, 2)) @(posedge i_clk);
    i_rready <= 1'b1;
    do @(posedge i_clk); while (o_rvalid !== 1'b1);
    i_rready <= 1'b0;
  endtask

  task automatic rx(input logic f, input logic [7:0] d);
    i_rx <= {1'b1, f, d};
    @(posedge i_clk);
  endtask

  task automatic chk_irq(input logic ex);
    repeat (2) @(posedge i_clk);
    cmp("irq", {33'h0, ex}, {33'h0, o_irq});
  endtask

  // Capture one frame and the idle run after it
  task automatic meas(input int n_len, output int lo);
    logic [7:0] b;
    logic [3:0] en;
    int         n;
    int         p;
    b = LFSR_SEED;
    n = 0;
    do @(posedge i_clk); while (o_tx.en !== 1'b1);
    while (o_tx.en === 1'b1) begin
      p = n - 15;
      en = (n < 14) ? PRE_NIB : (n == 14) ? SFD_BYTE[7:4] : (p[0] ? b[7:4] : b[3:0]);
      cmp("nibble", {30'h0, en}, {30'h0, o_tx.nib});
      if (n >= 15 && p[0])
        b = nx(b);
      n++;
      @(posedge i_clk);
    end
    cmp("length", 34'(15 + 2 * n_len), 34'(n));
    lo = 0;
    while (o_tx.en !== 1'b1) begin
      lo++;
      @(posedge i_clk);
    end
  endtask

  task automatic run_gen(input int n_len, input int gap, output int lo);
    wr(IDX_CFG, 32'h0);
    do @(posedge i_clk); while (o_tx.en !== 1'b0);
    wr(IDX_PKT_LEN, 32'(n_len));
    wr(IDX_GAP_LEN, 32'(gap));
    wr(IDX_CFG, 32'h1);
    meas(n_len, lo);
  endtask

  // Bus result watcher
  always @(posedge i_clk) begin
    if (o_rvalid === 1'b1 && i_rready === 1'b1)
      cmp("rdata", q_rd.pop_front(), {o_rresp, o_rdata});
    if (o_bvalid === 1'b1 && i_bready === 1'b1)
      cmp("bresp", {32'h0, q_b.pop_front()}, {32'h0, o_bresp});
  end

  // Watchdog
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 90000) begin
      err_total++;
      end_sim();
    end
  end

  ////////////////////////////////////////
  // Main sequence
  initial begin
    {i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    {i_awaddr, i_araddr, i_wdata} = '0;
    i_wstrb = 4'hF;
    i_rx = '0;
    void'($urandom(4721));
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(IDX_PKT_LEN, 32'h0000_05DC);
    rd(IDX_GAP_LEN, 32'h0000_007D);
    rd(IDX_CTRL_STS, 32'h0000_0000);
    rd(IDX_BYTE_CNT, 32'h0000_0000);
    rd(8'h90, 32'h0000_0000, RESP_SLVERR);
    wr(8'h90, 32'h0000_0000, RESP_SLVERR);
    wr(IDX_GAP_LEN, 32'hFFFF_FFFF);
    rd(IDX_GAP_LEN, 32'h0000_00FF);
    $display("test registers done");
    x = 8'($urandom);
    rx(1'b1, x);
    e = 0;
    repeat (40) begin
      x = nx(x);
      if ($urandom_range(0, 3) == 0) begin
        x = x ^ 8'($urandom_range(1, 255));
        e++;
      end
      rx(1'b0, x);
    end
    i_rx <= '0;
    wr(IDX_CTRL_STS, 32'h0000_0001);
    rd(IDX_BYTE_CNT, 32'd41);
    rd(IDX_CTRL_STS, 32'(e));
    repeat (5) rx(1'b0, nx(8'h00));
    i_rx <= '0;
    rd(IDX_BYTE_CNT, 32'd41);
    wr(IDX_CTRL_STS, 32'h0000_0002);
    rd(IDX_BYTE_CNT, 32'd46);
    wr(IDX_CTRL_STS, 32'h0000_0001);
    rd(IDX_BYTE_CNT, 32'h0000_0000);
    rd(IDX_CTRL_STS, 32'h0000_0000);
    // First zero byte of the burst breaks the sequence unless it follows a zero
    rd(IDX_IRQ_STS, 32'(e != 0 || nx(x) != 8'h00));
    $display("test snapshot done");
    repeat (65536) rx(1'b1, 8'hFF);
    i_rx <= '0;
    wr(IDX_CTRL_STS, 32'h0000_0001);
    rd(IDX_BYTE_CNT, 32'h0000_FFFF);
    rd(IDX_CTRL_STS, 32'h0000_0600);
    chk_irq(1'b0);
    wr(IDX_IRQ_MASK, 32'h0000_0004);
    chk_irq(1'b1);
    rd(IDX_IRQ_STS, 32'h0000_0006);
    chk_irq(1'b0);
    repeat (300) rx(1'b0, 8'hFF);
    i_rx <= '0;
    wr(IDX_CTRL_STS, 32'h0000_0002);
    rd(IDX_CTRL_STS, 32'h0000_00FF);
    wr(IDX_IRQ_MASK, 32'h0000_0001);
    chk_irq(1'b1);
    wr(IDX_IRQ_MASK, 32'h0000_0000);
    chk_irq(1'b0);
    // Wrap mode: 300 error bytes leave 300 modulo 256 in the error count
    wr(IDX_CFG, 32'h0000_0002);
    repeat (300) rx(1'b0, 8'hFF);
    i_rx <= '0;
    wr(IDX_CTRL_STS, 32'h0000_0002);
    rd(IDX_CTRL_STS, 32'h0000_002C);
    rd(IDX_BYTE_CNT, 32'h0000_012C);
    $display("test overflow done");
    wr(IDX_GAP_LEN, 32'h0000_007D);
    wr(IDX_CFG, 32'h0000_0001);
    meas(1500, lo0);
    len = $urandom_range(1, 6);
    g1 = $urandom_range(0, 3);
    g2 = g1 + $urandom_range(1, 4);
    run_gen(len, g1, lo1);
    cmp("gap", 34'(8 * (125 - g1)), 34'(lo0 - lo1));
    run_gen(len, g2, lo2);
    cmp("gap", 34'(8 * (g2 - g1)), 34'(lo2 - lo1));
    $display("test generator done");
    end_sim();
  end
endmodule
